// ==== bench/cmp_control_bench.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "cmp_regs.svh"
module cmp_control_bench;
  import cmp_pkg::*;
  typedef struct packed {
    logic [31:0] wr;
    logic [31:0] rd;
    logic        pin;
    logic        oe;
  } cmp_row_s;
  localparam logic [31:0] A_CTRL = {24'h0, `CMP_CTRL_OFFSET};
  localparam logic [31:0] A_STAT = {24'h0, `CMP_IRQ_STAT_OFFSET};
  localparam logic [31:0] A_CLR  = {24'h0, `CMP_IRQ_CLR_OFFSET};
  localparam logic [31:0] A_EN   = {24'h0, `CMP_IRQ_EN_OFFSET};
  logic        clk_sys_in;
  logic        rst_in;
  cmp_ahb_in_s mst;
  cmp_ahb_in_s ahb;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        raw;
  cmp_analog_s analog;
  logic        pin;
  logic        oe;
  logic        pulse;
  logic        irq;
  logic [7:0]  level [6];
  cmp_row_s    rows [10];
  int          err_count;
  int          compares;
  logic [31:0] rd;
  logic [31:0] cnt;
  logic        exp_rise;
  logic        exp_fall;

  cmp_control cmp_control_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ahb_in(ahb),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .comparator_raw_in(raw),
    .analog_ctrl_out(analog), .result_pin_out(pin), .result_pin_oe_out(oe),
    .edge_pulse_out(pulse), .irq_out(irq));
  // slow core so the sync path sees a late edge
  cmp_core_model #(.DELAY_NS(3)) cmp_core_model_i (.ctrl_in(analog), .level_in(level),
    .raw_out(raw));

  // the one slave's ready is the bus ready
  always_comb begin
    ahb = mst;
    ahb.hready = hready;
  end
  // 100 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic print_verdict();
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected bit at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // bounded wait: a hung slave ends the run instead of the simulator
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      err_count++;
      $display("unexpected bus hang at %0t", $time);
      print_verdict();
    end
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    mst.hsel   <= 1'b1;
    mst.haddr  <= addr;
    mst.htrans <= 2'b10;
    mst.hwrite <= wr;
    wait_ready();
    mst.hsel   <= 1'b0;
    mst.htrans <= 2'b00;
    mst.hwdata <= wdata;
    wait_ready();
    rd = hrdata;
  endtask
  // counts cycles with the pulse high, so a stretched pulse counts twice
  task automatic count_pulses(output logic [31:0] n);
    n = 0;
    repeat (12) begin
      @(posedge clk_sys_in);
      if (pulse === 1'b1) n++;
    end
  endtask

  initial begin
    err_count = 0;
    compares = 0;
    rst_in = 1'b1;
    mst = '0;
    mst.hsize = 3'b010;
    level = '{8'd100, 8'd50, 8'd80, 8'd120, 8'd40, 8'd60};
    rows = '{'{32'h8000, 32'h8100, 1'b0, 1'b0}, '{32'hc001, 32'hc001, 1'b0, 1'b1},
      '{32'hc002, 32'hc102, 1'b1, 1'b1}, '{32'he003, 32'he003, 1'b0, 1'b1},
      '{32'hc010, 32'hc010, 1'b0, 1'b1}, '{32'he012, 32'he012, 1'b0, 1'b1},
      '{32'he011, 32'he111, 1'b1, 1'b1}, '{32'h2000, 32'h2100, 1'b0, 1'b0},
      '{32'hffffffff, 32'he1d3, 1'b1, 1'b1}, '{32'h6fd3, 32'h61d3, 1'b1, 1'b1}};
    cyc(20);
    rst_in <= 1'b0;
    xfer(1'b0, A_CTRL, 32'h0);
    chk_word(rd, 32'h000000c3);
    chk_word({28'h0, analog}, 32'h3);
    xfer(1'b1, 32'h10, 32'hffffffff);
    xfer(1'b0, 32'h10, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(hresp, 1'b0);
    // field routing, inversion and readback; settle covers the sync path
    foreach (rows[i]) begin
      xfer(1'b1, A_CTRL, rows[i].wr);
      cyc(8);
      xfer(1'b0, A_CTRL, 32'h0);
      chk_word(rd, rows[i].rd);
      chk_word(32'(analog), 32'({rows[i].wr[15], rows[i].wr[4], rows[i].wr[1:0]}));
      chk_bit(pin, rows[i].pin);
      chk_bit(oe, rows[i].oe);
    end
    // every polarity code with and without inversion
    xfer(1'b1, A_EN, 32'h1);
    for (int m = 0; m < 8; m++) begin
      exp_rise = m[2] ? m[1] : m[0];
      exp_fall = m[2] ? m[0] : m[1];
      level[0] <= 8'd0;
      xfer(1'b1, A_CTRL, {16'h0, 1'b1, 1'b0, m[2], 5'h0, m[1:0], 6'h0});
      cyc(8);
      xfer(1'b1, A_CLR, 32'h1);
      level[0] <= 8'd100;
      count_pulses(cnt);
      chk_word(cnt, {31'h0, exp_rise});
      chk_bit(irq, exp_rise);
      xfer(1'b1, A_CLR, 32'h1);
      level[0] <= 8'd0;
      count_pulses(cnt);
      chk_word(cnt, {31'h0, exp_fall});
      xfer(1'b0, A_STAT, 32'h0);
      chk_word(rd, {31'h0, exp_fall});
    end
    // masked event stays sticky, shows once unmasked, then clears
    xfer(1'b1, A_EN, 32'h0);
    xfer(1'b1, A_CLR, 32'h1);
    level[0] <= 8'd100;
    cyc(10);
    chk_bit(irq, 1'b0);
    xfer(1'b0, A_STAT, 32'h0);
    chk_word(rd, 32'h1);
    xfer(1'b1, A_EN, 32'h1);
    cyc(2);
    chk_bit(irq, 1'b1);
    xfer(1'b1, A_CLR, 32'h1);
    cyc(2);
    chk_bit(irq, 1'b0);
    // second reset in mid-run restores the defaults
    rst_in <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    xfer(1'b0, A_CTRL, 32'h0);
    chk_word(rd, 32'h000000c3);
    chk_bit(oe, 1'b0);
    print_verdict();
  end
endmodule // cmp_control_bench
`default_nettype wire

// ==== bench/cmp_core_model.sv ====
// behavioural analog comparator core with steerable inputs
`timescale 1ns/10ps
`default_nettype none
module cmp_core_model #(
  parameter int DELAY_NS = 0
) (
  input  wire cmp_pkg::cmp_analog_s ctrl_in,
  input  wire logic [7:0]           level_in [6],
  output logic                      raw_out
);
  import cmp_pkg::*;
  logic [7:0] plus_lv;
  logic [7:0] minus_lv;
  // levels: 0 pin a, 1 programmable ref, 2-4 pins b-d, 5 fixed ref
  assign plus_lv  = ctrl_in.positive_input_select ? level_in[1] : level_in[0];
  assign minus_lv = level_in[3'(ctrl_in.negative_input_select) + 3'd2];
  // a switched-off core idles low; the delay stands for a slow settle
  assign #(DELAY_NS) raw_out = ctrl_in.enable & (plus_lv > minus_lv);
endmodule // cmp_core_model
`default_nettype wire

// ==== hw/cmp_control.sv ====
// comparator channel control register, output steering and edge interrupt
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_regs.svh"

// Notes on behaviour
// - enable set leaves other fields intact
// - enable clear leaves other fields intact
// - pin enable drives result onto pin
// - invert bit flips presented result
// - inversion also feeds edge detection
// - result bit shows current output
// - polarity field picks off/rise/fall/both
// - positive select picks reference or pin
// - negative select picks b/c/d/fixed reference
// - unimplemented bits read zero, ignore writes
module cmp_control (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  input  wire cmp_pkg::cmp_ahb_in_s ahb_in,
  output logic [31:0]               hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  input  wire logic                 comparator_raw_in,
  output cmp_pkg::cmp_analog_s      analog_ctrl_out,
  output logic                      result_pin_out,
  output logic                      result_pin_oe_out,
  output logic                      edge_pulse_out,
  output logic                      irq_out
);
  import cmp_pkg::*;

  cmp_ctrl_s   ctrl_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        result_q;
  logic        result_prev_q;
  logic        irq_stat_q;
  logic        irq_en_q;
  logic        dph_valid_q;
  logic        dph_write_q;
  logic [7:0]  dph_addr_q;
  logic        result_now;
  logic        edge_hit;
  logic        wr_ctrl;
  logic        wr_clr;
  logic        wr_en;
  logic        addr_take;
  logic [31:0] rd_word;

  // address phase is taken when selected, non-idle and the bus is ready
  assign addr_take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q  <= 8'h00;
    end else if (ahb_in.hready) begin
      dph_valid_q <= addr_take;
      dph_write_q <= ahb_in.hwrite;
      dph_addr_q  <= ahb_in.haddr[7:0];
    end
  end

  assign wr_ctrl = dph_valid_q && dph_write_q && (dph_addr_q == `CMP_CTRL_OFFSET);
  assign wr_clr  = dph_valid_q && dph_write_q && (dph_addr_q == `CMP_IRQ_CLR_OFFSET);
  assign wr_en   = dph_valid_q && dph_write_q && (dph_addr_q == `CMP_IRQ_EN_OFFSET);

  // zero wait states: always ready, always okay
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // control fields; each write stores every implemented field at once
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q.enable                <= 1'b0;
      ctrl_q.output_pin_enable     <= 1'b0;
      ctrl_q.output_invert         <= 1'b0;
      ctrl_q.event_polarity        <= cmp_event_polarity_e'(`CMP_EVENT_POLARITY_RESET);
      ctrl_q.positive_input_select <= 1'b0;
      ctrl_q.negative_input_select <= cmp_neg_sel_e'(`CMP_NEG_SEL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q.enable                <= ahb_in.hwdata[`CMP_ENABLE_BIT];
      ctrl_q.output_pin_enable     <= ahb_in.hwdata[`CMP_PIN_EN_BIT];
      ctrl_q.output_invert         <= ahb_in.hwdata[`CMP_INVERT_BIT];
      ctrl_q.event_polarity        <=
        cmp_event_polarity_e'(ahb_in.hwdata[`CMP_EVENT_POLARITY_HI:`CMP_EVENT_POLARITY_LO]);
      ctrl_q.positive_input_select <= ahb_in.hwdata[`CMP_POS_SEL_BIT];
      ctrl_q.negative_input_select <=
        cmp_neg_sel_e'(ahb_in.hwdata[`CMP_NEG_SEL_HI:`CMP_NEG_SEL_LO]);
    end
  end

  // analog steering is registered so outputs come straight from flops
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      analog_ctrl_out <= '{enable: 1'b0, positive_input_select: 1'b0,
                           negative_input_select: cmp_neg_sel_e'(`CMP_NEG_SEL_RESET)};
    end else begin
      analog_ctrl_out.enable                <= ctrl_q.enable;
      analog_ctrl_out.positive_input_select <= ctrl_q.positive_input_select;
      analog_ctrl_out.negative_input_select <= ctrl_q.negative_input_select;
    end
  end

  // two-flop synchroniser; the analog output is asynchronous to the bus clock
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= comparator_raw_in;
      sync2_q <= sync1_q;
    end
  end

  // a disabled comparator reads low before inversion (high when inverted); inversion applied before edge logic
  assign result_now = (sync2_q & ctrl_q.enable) ^ ctrl_q.output_invert;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      result_q      <= 1'b0;
      result_prev_q <= 1'b0;
    end else begin
      result_q      <= result_now;
      result_prev_q <= result_q;
    end
  end

  // edge qualifier per polarity setting
  always_comb begin
    unique case (ctrl_q.event_polarity)
      CMP_EV_OFF:  edge_hit = 1'b0;
      CMP_EV_RISE: edge_hit = result_q & ~result_prev_q;
      CMP_EV_FALL: edge_hit = ~result_q & result_prev_q;
      CMP_EV_BOTH: edge_hit = result_q ^ result_prev_q;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      edge_pulse_out <= 1'b0;
    end else begin
      edge_pulse_out <= edge_hit;
    end
  end

  // pin drive: a released pin is held low so it is never undefined
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      result_pin_out    <= 1'b0;
      result_pin_oe_out <= 1'b0;
    end else begin
      result_pin_out    <= ctrl_q.output_pin_enable & result_now;
      result_pin_oe_out <= ctrl_q.output_pin_enable;
    end
  end

  // sticky status: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= 1'b0;
    end else if (edge_hit) begin
      irq_stat_q <= 1'b1;
    end else if (wr_clr && ahb_in.hwdata[`CMP_IRQ_EDGE_BIT]) begin
      irq_stat_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_q <= 1'b0;
    end else if (wr_en) begin
      irq_en_q <= ahb_in.hwdata[`CMP_IRQ_EDGE_BIT];
    end
  end

  // level interrupt, one cycle behind the status bit
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_stat_q & irq_en_q;
    end
  end

  // read mux; unmapped and clear-register reads return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (ahb_in.haddr[7:0])
      `CMP_CTRL_OFFSET: begin
        rd_word[`CMP_ENABLE_BIT]                 = ctrl_q.enable;
        rd_word[`CMP_PIN_EN_BIT]                 = ctrl_q.output_pin_enable;
        rd_word[`CMP_INVERT_BIT]                 = ctrl_q.output_invert;
        rd_word[`CMP_RESULT_BIT]                 = result_q;
        rd_word[`CMP_EVENT_POLARITY_HI:`CMP_EVENT_POLARITY_LO]     = ctrl_q.event_polarity;
        rd_word[`CMP_POS_SEL_BIT]                = ctrl_q.positive_input_select;
        rd_word[`CMP_NEG_SEL_HI:`CMP_NEG_SEL_LO] = ctrl_q.negative_input_select;
      end
      `CMP_IRQ_STAT_OFFSET: rd_word[`CMP_IRQ_EDGE_BIT] = irq_stat_q;
      `CMP_IRQ_EN_OFFSET:   rd_word[`CMP_IRQ_EDGE_BIT] = irq_en_q;
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  // read data is latched at the address phase and stands in the data phase
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (addr_take && !ahb_in.hwrite) begin
      hrdata_out <= rd_word;
    end
  end

  // checks on the behaviour rules, next to the logic they guard
  property p_enable_write;
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_ctrl |=> (ctrl_q.enable == $past(ahb_in.hwdata[`CMP_ENABLE_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow write");

  property p_disable_keeps;
    @(posedge clk_sys_in) disable iff (rst_in)
    (wr_ctrl && !ahb_in.hwdata[`CMP_ENABLE_BIT]) |=> ##1 !analog_ctrl_out.enable;
  endproperty
  a_disable_keeps: assert property (p_disable_keeps)
    else $error("analog core not disabled after clear");

  property p_pin_release;
    @(posedge clk_sys_in) disable iff (rst_in)
    !ctrl_q.output_pin_enable |=> !result_pin_oe_out;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin driven while disabled");

  property p_pin_value;
    @(posedge clk_sys_in) disable iff (rst_in)
    ctrl_q.output_pin_enable |=> (result_pin_out == $past(result_now));
  endproperty
  a_pin_value: assert property (p_pin_value)
    else $error("pin value wrong");

  // with inversion a falling comparator output must fire a rising-edge request
  property p_invert_flip;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl_q.enable && ctrl_q.output_invert && ctrl_q.event_polarity == CMP_EV_RISE &&
     $stable(ctrl_q) && !wr_ctrl && $fell(sync2_q)) |=> ##1 edge_pulse_out;
  endproperty
  a_invert_flip: assert property (p_invert_flip)
    else $error("inversion not applied to edge path");

  property p_rise_edge;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl_q.event_polarity == CMP_EV_RISE && $rose(result_q)) |=> edge_pulse_out;
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge missed");

  property p_off_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl_q.event_polarity == CMP_EV_OFF) |=> !edge_pulse_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("edge reported while disabled");

  property p_single_pulse;
    @(posedge clk_sys_in) disable iff (rst_in)
    (edge_pulse_out && $stable(result_q)) |=> !edge_pulse_out;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("edge pulse longer than one cycle");

  property p_sel_route;
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_ctrl |=> ##1 (analog_ctrl_out.negative_input_select ==
                     $past(ahb_in.hwdata[`CMP_NEG_SEL_HI:`CMP_NEG_SEL_LO], 2));
  endproperty
  a_sel_route: assert property (p_sel_route)
    else $error("negative select not routed");

  property p_reserved_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
    (addr_take && !ahb_in.hwrite && ahb_in.haddr[7:0] == `CMP_CTRL_OFFSET)
      |=> (hrdata_out[31:16] == 16'h0000 && hrdata_out[12:9] == 4'h0 &&
           !hrdata_out[5] && hrdata_out[3:2] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented bits read nonzero");

endmodule : cmp_control
`default_nettype wire

// ==== hw/cmp_pkg.sv ====
// types shared by the comparator control block
`default_nettype none
package cmp_pkg;

  typedef enum logic [1:0] {
    CMP_EV_OFF,
    CMP_EV_RISE,
    CMP_EV_FALL,
    CMP_EV_BOTH
  } cmp_event_polarity_e;

  typedef enum logic [1:0] {
    CMP_NEG_PIN_B,
    CMP_NEG_PIN_C,
    CMP_NEG_PIN_D,
    CMP_NEG_FIXED_REF
  } cmp_neg_sel_e;

  // stored control fields
  typedef struct packed {
    logic         enable;
    logic         output_pin_enable;
    logic         output_invert;
    cmp_event_polarity_e   event_polarity;
    logic         positive_input_select;
    cmp_neg_sel_e negative_input_select;
  } cmp_ctrl_s;

  // analog core steering
  typedef struct packed {
    logic         enable;
    logic         positive_input_select;
    cmp_neg_sel_e negative_input_select;
  } cmp_analog_s;

  // ahb-lite slave inputs
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } cmp_ahb_in_s;

endpackage : cmp_pkg
`default_nettype wire

// ==== hw/cmp_regs.svh ====
// register offsets, field positions and reset values of the comparator control block
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

`define CMP_CTRL_OFFSET     8'h00
`define CMP_IRQ_STAT_OFFSET 8'h04
`define CMP_IRQ_CLR_OFFSET  8'h08
`define CMP_IRQ_EN_OFFSET   8'h0c

`define CMP_ENABLE_BIT      15
`define CMP_PIN_EN_BIT      14
`define CMP_INVERT_BIT      13
`define CMP_RESULT_BIT      8
`define CMP_EVENT_POLARITY_HI        7
`define CMP_EVENT_POLARITY_LO        6
`define CMP_POS_SEL_BIT     4
`define CMP_NEG_SEL_HI      1
`define CMP_NEG_SEL_LO      0

`define CMP_EVENT_POLARITY_RESET     2'h3
`define CMP_NEG_SEL_RESET   2'h3

`define CMP_IRQ_EDGE_BIT    0

`endif
